// ---- bounce_cfg.svh ----
`ifndef BOUNCE_CFG_SVH
`define BOUNCE_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_EXC_CTL      4'h0
`define OFS_FAULT_INSTR  4'h4
`define OFS_SECOND_INSTR 4'h8
`define OFS_STATUS_CTL   4'hC

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_PENDING      31
`define BIT_SECOND_VALID 28
`define BIT_INV_CUM      0
`define BIT_UFC          3
`define BIT_FAST_MODE    24

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define RST_WORD         32'h0000_0000
`define RST_FAST_MODE    1'h0
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ---- bounce_pkg.sv ----
package bounce_pkg;

  // Gray order: idle -> exceptional -> idle
  typedef enum logic [1:0] {
    EXC_IDLE        = 2'h0,
    EXC_EXCEPTIONAL = 2'h1
  } exc_state_type;

  typedef struct packed {
    exc_state_type exc;
    logic          aw_held;
    logic          w_held;
    logic [3:0]    awaddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic          fast_mode;
  } core_state_type;

endpackage : bounce_pkg

// ---- sticky_flag.sv ----
`timescale 1ns/1ps

module sticky_flag (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_set,
  input  wire logic i_clr,
  output logic      o_flag
);

  typedef struct packed {
    logic flag;
  } flag_state_type;

  flag_state_type state;
  flag_state_type next_state;

  // A set in the clearing cycle is kept
  always_comb begin
    next_state.flag = i_set | (state.flag & ~i_clr);
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state.flag <= 1'h0;
    end else begin
      state <= next_state;
    end
  end

  assign o_flag = state.flag;

endmodule : sticky_flag

// ---- word_capture.sv ----
`timescale 1ns/1ps

module word_capture #(
  parameter int WIDTH = 32
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_word,
  output logic      [WIDTH-1:0] o_word
);

  typedef struct packed {
    logic [WIDTH-1:0] word;
  } cap_state_type;

  cap_state_type state;
  cap_state_type next_state;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("word_capture: WIDTH must be at least 1");
    end
  endgenerate

  always_comb begin
    next_state = state;
    if (i_load) begin
      next_state.word = i_word;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state.word <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_word = state.word;

endmodule : word_capture

// ---- fp_coprocessor_bounce_unit.sv ----
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "bounce_cfg.svh"

module fp_coprocessor_bounce_unit #(
  parameter int ADDR_W = 4
) (
  input  wire logic                i_clk,
  input  wire logic                i_srst,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]   i_awaddr,
  input  wire logic                i_awvalid,
  output logic                     o_awready,
  input  wire logic [31:0]         i_wdata,
  input  wire logic [3:0]          i_wstrb,
  input  wire logic                i_wvalid,
  output logic                     o_wready,
  output logic [1:0]               o_bresp,
  output logic                     o_bvalid,
  input  wire logic                i_bready,
  input  wire logic [ADDR_W-1:0]   i_araddr,
  input  wire logic                i_arvalid,
  output logic                     o_arready,
  output logic [31:0]              o_rdata,
  output logic [1:0]               o_rresp,
  output logic                     o_rvalid,
  input  wire logic                i_rready,
  // Host coprocessor handshake (decode stage)
  input  wire logic                i_cp_valid,
  input  wire logic [31:0]         i_cp_instr,
  input  wire logic                i_cp_illegal,
  output logic                     o_cp_accept,
  output logic                     o_cp_bounce,
  // First execute stage report
  input  wire logic                i_op_valid,
  input  wire logic [31:0]         i_op_instr,
  input  wire logic                i_op_arith,
  input  wire logic                i_op_copy,
  input  wire logic                i_op_vector,
  input  wire logic                i_op_enabled_exc,
  input  wire logic                i_op_potential_exc,
  input  wire logic                i_op_snan,
  input  wire logic                i_op_underflow,
  input  wire logic                i_op_flushed_zero,
  // Execute control
  output logic                     o_op_block,
  output logic                     o_vec_stop,
  output logic                     o_flush_subnormal,
  output logic                     o_exc_pending
);
  import bounce_pkg::*;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  generate
    if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
      $error("fp_coprocessor_bounce_unit: ADDR_W must be 4..32");
    end
  endgenerate

  core_state_type state;
  core_state_type next_state;

  logic        pending;
  logic        second_valid;
  logic        inv_flag;
  logic        ufc_flag;
  logic [31:0] fault_word;
  logic [31:0] second_word;

  logic        op_can_raise;
  logic        detect;
  logic        pretrigger;
  logic        wr_fire;
  logic        wr_exc_ctl;
  logic        wr_status;
  logic        pend_clr;
  logic        inv_set;
  logic        inv_clr;
  logic        ufc_set;
  logic        ufc_clr;
  logic [3:0]  ar_ofs;
  logic [31:0] exc_ctl_view;
  logic [31:0] status_view;

  assign pending = (state.exc == EXC_EXCEPTIONAL);

  // ----------------------------------------
  // Exception detection
  // ----------------------------------------
  // Only true arithmetic may raise
  // arithmetic only
  assign op_can_raise = i_op_valid & i_op_arith & ~i_op_copy;

  // Potential alone is enough; a second one waits until software
  // has cleared the first, so the captured word never moves.
  // pessimistic detect
  assign detect = op_can_raise & ~pending
                  & (i_op_enabled_exc | i_op_potential_exc);

  // Offending operation itself must not complete
  assign o_op_block = detect;

  assign o_vec_stop = (detect & i_op_vector) | pending;

  assign o_flush_subnormal = state.fast_mode & ~i_op_copy;

  // ----------------------------------------
  // Coprocessor handshake
  // ----------------------------------------
  // Refusal is decided combinationally in the first handshake cycle so
  // the host never lets the trigger take effect.
  // signal by refusal
  assign o_cp_bounce = i_cp_valid & (pending | i_cp_illegal);

  assign o_cp_accept = i_cp_valid & ~pending & ~i_cp_illegal;

  // An instruction accepted in the detection cycle has already passed
  // the host's exception point, so it is kept for software.
  // trigger comes later
  assign pretrigger = detect & o_cp_accept;

  assign o_exc_pending = pending;

  // ----------------------------------------
  // Captured words and flags
  // ----------------------------------------
  // capture offending word
  word_capture #(
    .WIDTH (32)
  ) u_fault_word (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_load (detect),
    .i_word (i_op_instr),
    .o_word (fault_word)
  );

  word_capture #(
    .WIDTH (32)
  ) u_second_word (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_load (pretrigger),
    .i_word (i_cp_instr),
    .o_word (second_word)
  );

  sticky_flag u_second_valid (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_set  (pretrigger),
    .i_clr  (pend_clr),
    .o_flag (second_valid)
  );

  assign inv_set = op_can_raise & i_op_snan;

  sticky_flag u_inv (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_set  (inv_set),
    .i_clr  (inv_clr),
    .o_flag (inv_flag)
  );

  assign ufc_set = op_can_raise
                   & (i_op_underflow | (state.fast_mode & i_op_flushed_zero));

  sticky_flag u_ufc (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_set  (ufc_set),
    .i_clr  (ufc_clr),
    .o_flag (ufc_flag)
  );

  // ----------------------------------------
  // Register write decode
  // ----------------------------------------
  assign wr_fire    = state.aw_held & state.w_held & ~state.bvalid;
  assign wr_exc_ctl = wr_fire & (state.awaddr == `OFS_EXC_CTL);
  assign wr_status  = wr_fire & (state.awaddr == `OFS_STATUS_CTL);

  // Writing zero to the pending bit leaves the exceptional state; a
  // detection in that cycle is impossible while pending, and when idle
  // detection simply wins.
  // software clears pending
  assign pend_clr = wr_exc_ctl & state.wstrb[3] & ~state.wdata[`BIT_PENDING];

  assign inv_clr = wr_status & state.wstrb[0] & ~state.wdata[`BIT_INV_CUM];
  assign ufc_clr = wr_status & state.wstrb[0] & ~state.wdata[`BIT_UFC];

  // ----------------------------------------
  // Register read views
  // ----------------------------------------
  // pending visible first
  always_comb begin
    exc_ctl_view                    = `RST_WORD;
    exc_ctl_view[`BIT_PENDING]      = pending;
    exc_ctl_view[`BIT_SECOND_VALID] = second_valid;
  end

  always_comb begin
    status_view                 = `RST_WORD;
    status_view[`BIT_INV_CUM]   = inv_flag;
    status_view[`BIT_UFC]       = ufc_flag;
    status_view[`BIT_FAST_MODE] = state.fast_mode;
  end

  assign ar_ofs = i_araddr[3:0];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_state = state;

    case (state.exc)
      EXC_IDLE: begin
        if (detect) begin
          next_state.exc = EXC_EXCEPTIONAL;
        end
      end
      EXC_EXCEPTIONAL: begin
        if (pend_clr) begin
          next_state.exc = EXC_IDLE;
        end
      end
      default: begin
        next_state.exc = EXC_IDLE;
      end
    endcase

    // Write address and data are taken independently
    if (o_awready && i_awvalid) begin
      next_state.aw_held = 1'h1;
      next_state.awaddr  = i_awaddr[3:0];
    end
    if (o_wready && i_wvalid) begin
      next_state.w_held = 1'h1;
      next_state.wdata  = i_wdata;
      next_state.wstrb  = i_wstrb;
    end

    if (wr_fire) begin
      next_state.aw_held = 1'h0;
      next_state.w_held  = 1'h0;
      next_state.bvalid  = 1'h1;
      next_state.bresp   = `RESP_OKAY;
      case (state.awaddr)
        `OFS_EXC_CTL: begin
        end
        `OFS_FAULT_INSTR: begin
        end
        `OFS_SECOND_INSTR: begin
        end
        `OFS_STATUS_CTL: begin
          if (state.wstrb[3]) begin
            next_state.fast_mode = state.wdata[`BIT_FAST_MODE];
          end
        end
        default: begin
          next_state.bresp = `RESP_SLVERR;
        end
      endcase
    end else if (state.bvalid && i_bready) begin
      next_state.bvalid = 1'h0;
    end

    if (o_arready && i_arvalid) begin
      next_state.rvalid = 1'h1;
      next_state.rresp  = `RESP_OKAY;
      case (ar_ofs)
        `OFS_EXC_CTL:      next_state.rdata = exc_ctl_view;
        `OFS_FAULT_INSTR:  next_state.rdata = fault_word;
        `OFS_SECOND_INSTR: next_state.rdata = second_word;
        `OFS_STATUS_CTL:   next_state.rdata = status_view;
        default: begin
          next_state.rdata = `RST_WORD;
          next_state.rresp = `RESP_SLVERR;
        end
      endcase
    end else if (state.rvalid && i_rready) begin
      next_state.rvalid = 1'h0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state.exc       <= EXC_IDLE;
      state.aw_held   <= 1'h0;
      state.w_held    <= 1'h0;
      state.awaddr    <= 4'h0;
      state.wdata     <= `RST_WORD;
      state.wstrb     <= 4'h0;
      state.bvalid    <= 1'h0;
      state.bresp     <= `RESP_OKAY;
      state.rvalid    <= 1'h0;
      state.rdata     <= `RST_WORD;
      state.rresp     <= `RESP_OKAY;
      state.fast_mode <= `RST_FAST_MODE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Bus outputs
  // ----------------------------------------
  // One write in flight: no new address or data until the answer leaves
  assign o_awready = ~state.aw_held & ~state.bvalid;
  assign o_wready  = ~state.w_held & ~state.bvalid;
  assign o_bvalid  = state.bvalid;
  assign o_bresp   = state.bresp;
  assign o_arready = ~state.rvalid;
  assign o_rvalid  = state.rvalid;
  assign o_rdata   = state.rdata;
  assign o_rresp   = state.rresp;

endmodule : fp_coprocessor_bounce_unit

// ---- bounce_unit_props.sv ----
`timescale 1ns/1ps

module bounce_unit_props (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic o_bvalid,
  input wire logic i_cp_valid,
  input wire logic i_cp_illegal,
  input wire logic o_cp_accept,
  input wire logic o_cp_bounce,
  input wire logic i_op_valid,
  input wire logic i_op_arith,
  input wire logic i_op_copy,
  input wire logic i_op_vector,
  input wire logic i_op_enabled_exc,
  input wire logic i_op_potential_exc,
  input wire logic o_op_block,
  input wire logic o_vec_stop,
  input wire logic o_flush_subnormal,
  input wire logic o_exc_pending
);
  // ----------------------------------------
  // Detection seen from the ports
  // ----------------------------------------
  logic det;
  assign det = i_op_valid & i_op_arith & !i_op_copy
             & (i_op_enabled_exc | i_op_potential_exc) & !o_exc_pending;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  pending_bounce_a:
    assert property (i_cp_valid && o_exc_pending |-> o_cp_bounce && !o_cp_accept)
    else $error("offered instruction not refused while pending");
  detect_entry_a:
    assert property (det |-> o_op_block ##1 o_exc_pending)
    else $error("detection did not block and enter pending");
  nonarith_quiet_a:
    assert property (i_op_valid && (i_op_copy || !i_op_arith) && !o_exc_pending
                     |-> !o_op_block ##1 !o_exc_pending)
    else $error("non-arithmetic operation raised an exception");
  illegal_alone_a:
    assert property (i_cp_valid && i_cp_illegal && !det && !o_exc_pending
                     |-> o_cp_bounce ##1 !o_exc_pending)
    else $error("illegal refusal touched the pending bit");
  state_holds_a:
    assert property ($fell(o_exc_pending) |-> $rose(o_bvalid))
    else $error("pending bit dropped without a register write");
  vector_stop_a:
    assert property ((det && i_op_vector) || o_exc_pending |-> o_vec_stop)
    else $error("later vector iterations not suppressed");
  copy_no_flush_a:
    assert property (i_op_copy |-> !o_flush_subnormal)
    else $error("copy would flush a subnormal");
  accept_free_a:
    assert property (i_cp_valid && !i_cp_illegal && !o_exc_pending
                     |-> o_cp_accept && !o_cp_bounce)
    else $error("legal instruction refused with nothing pending");

  cover property (det && i_cp_valid);
  cover property (o_exc_pending && i_cp_valid);
  cover property ($fell(o_exc_pending));
  cover property (det && i_op_vector);
endmodule : bounce_unit_props

bind fp_coprocessor_bounce_unit bounce_unit_props props_inst (
  .i_clk, .i_srst, .o_bvalid, .i_cp_valid, .i_cp_illegal, .o_cp_accept, .o_cp_bounce,
  .i_op_valid, .i_op_arith, .i_op_copy, .i_op_vector, .i_op_enabled_exc,
  .i_op_potential_exc, .o_op_block, .o_vec_stop, .o_flush_subnormal, .o_exc_pending
);

// ---- host_model.sv ----
`timescale 1ns/1ps

module host_model (
  input  wire logic        i_clk,
  input  wire logic        i_go,
  input  wire logic [31:0] i_word,
  input  wire logic        i_illegal,
  output logic             o_cp_valid,
  output logic [31:0]      o_cp_instr,
  output logic             o_cp_illegal
);
  logic [31:0] last = 32'h0;

  always_ff @(posedge i_clk) begin
    if (i_go) begin
      last <= i_word;
    end
  end

  // one-cycle offer
  // Idle word is inverted so a stale instruction never looks valid
  assign o_cp_valid   = i_go;
  assign o_cp_instr   = i_go ? i_word : ~last;
  assign o_cp_illegal = i_go & i_illegal;
endmodule : host_model

// ---- tb_fp_coprocessor_bounce_unit.sv ----
`timescale 1ns/1ps

module tb_fp_coprocessor_bounce_unit;
  localparam logic [8:0] V = 9'h100, AR = 9'h080, CP = 9'h040, VEC = 9'h020, EN = 9'h010;
  localparam logic [8:0] POT = 9'h008, SN = 9'h004, FZ = 9'h001;
  logic        i_clk = 1'h0, i_srst = 1'h1, go = 1'h0, ill = 1'h0;
  logic [3:0]  i_awaddr = 4'h0, i_araddr = 4'h0, i_wstrb = 4'h0;
  logic [31:0] i_wdata = 32'h0, i_op_instr = 32'h0, word = 32'h0, i_cp_instr, o_rdata, rd;
  logic        i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
  logic        i_arvalid = 1'h0, i_rready = 1'h0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]  o_bresp, o_rresp, resp;
  logic        i_cp_valid, i_cp_illegal, o_cp_accept, o_cp_bounce;
  logic        i_op_valid, i_op_arith, i_op_copy, i_op_vector, i_op_enabled_exc;
  logic        i_op_potential_exc, i_op_snan, i_op_underflow, i_op_flushed_zero;
  logic        o_op_block, o_vec_stop, o_flush_subnormal, o_exc_pending;
  logic [8:0]  op = 9'h0;
  logic [8:0]  quiet [3] = '{V | AR | CP | POT, V | CP | EN | SN, V | EN | POT};
  int          failures = 0, checks_done = 0, cycles = 0;

  assign {i_op_valid, i_op_arith, i_op_copy, i_op_vector, i_op_enabled_exc,
          i_op_potential_exc, i_op_snan, i_op_underflow, i_op_flushed_zero} = op;

  always #50 i_clk = ~i_clk;

  fp_coprocessor_bounce_unit fp_coprocessor_bounce_unit_inst (
    .i_clk, .i_srst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid,
    .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
    .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_cp_valid, .i_cp_instr, .i_cp_illegal,
    .o_cp_accept, .o_cp_bounce, .i_op_valid, .i_op_instr, .i_op_arith, .i_op_copy,
    .i_op_vector, .i_op_enabled_exc, .i_op_potential_exc, .i_op_snan, .i_op_underflow,
    .i_op_flushed_zero, .o_op_block, .o_vec_stop, .o_flush_subnormal, .o_exc_pending
  );

  host_model host_model_inst (
    .i_clk, .i_go(go), .i_word(word), .i_illegal(ill),
    .o_cp_valid(i_cp_valid), .o_cp_instr(i_cp_instr), .o_cp_illegal(i_cp_illegal)
  );

  // ----------------------------------------
  // Checks and bus tasks
  // ----------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= s;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    do begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'h0;
      if (o_wready) i_wvalid <= 1'h0;
    end while (!o_bvalid);
    chk_word({30'h0, o_bresp}, 32'h0);
  endtask : wr

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    do begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 1'h0;
    end while (!o_rvalid);
    d = o_rdata;
    r = o_rresp;
  endtask : rd_reg

  task automatic chk_reg(input logic [3:0] a, input logic [31:0] exp);
    rd_reg(a, rd, resp);
    chk_word(rd, exp);
    chk_word({30'h0, resp}, 32'h0);
  endtask : chk_reg

  // Offer one instruction; the answer is sampled in its own cycle
  task automatic issue(input logic [31:0] w, input logic il, input logic exp_b);
    word <= w;
    ill <= il;
    go <= 1'h1;
    @(posedge i_clk);
    chk_bit(o_cp_bounce, exp_b);
    chk_bit(o_cp_accept, !exp_b);
    go <= 1'h0;
    op <= 9'h0;
    // Idle edge so the next call never reassigns these in this time step
    @(posedge i_clk);
  endtask : issue

  task automatic step(input logic [8:0] f, input logic [31:0] w, input logic exp_blk);
    op <= f;
    i_op_instr <= w;
    @(posedge i_clk);
    chk_bit(o_op_block, exp_blk);
    op <= 9'h0;
  endtask : step

  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // Hang guard, far above the hundred or so cycles the tests need
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      test_done();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge i_clk);
    i_srst <= 1'h0;
    for (int a = 0; a < 16; a += 4) chk_reg(a[3:0], 32'h0);
    rd_reg(4'h2, rd, resp);
    chk_word({30'h0, resp}, 32'h2);
    $display("test reset done");

    foreach (quiet[k]) begin
      step(quiet[k], 32'hA5A5_0001, 1'h0);
      issue(32'h0000_1111, 1'h0, 1'h0);
    end
    chk_reg(4'h0, 32'h0);
    chk_reg(4'hC, 32'h0);
    $display("test quiet ops done");

    wr(4'hC, 32'h0100_0000, 4'hF);
    chk_bit(o_flush_subnormal, 1'h1);
    step(V | AR | SN | FZ, 32'h0, 1'h0);
    chk_reg(4'hC, 32'h0100_0009);
    wr(4'hC, 32'h0, 4'hF);
    chk_reg(4'hC, 32'h0);
    $display("test fast mode done");

    op <= V | AR | VEC | POT;
    i_op_instr <= 32'hC0DE_0A01;
    issue(32'hC0DE_0B02, 1'h0, 1'h0);
    step(V | AR | EN, 32'hC0DE_0D04, 1'h0);
    issue(32'hC0DE_0C03, 1'h0, 1'h1);
    chk_reg(4'h0, 32'h9000_0000);
    chk_reg(4'h4, 32'hC0DE_0A01);
    chk_reg(4'h8, 32'hC0DE_0B02);
    wr(4'h0, 32'h0, 4'h8);
    chk_reg(4'h0, 32'h0);
    issue(32'hC0DE_0C03, 1'h0, 1'h0);
    $display("test pre-trigger done");

    for (int k = 0; k < 2; k++) begin
      step(k ? (V | AR | EN) : (V | AR | POT), 32'h0000_E100 + k, 1'h1);
      repeat (3) @(posedge i_clk);
      issue(32'h0000_F100, 1'h0, 1'h1);
      chk_reg(4'h0, 32'h8000_0000);
      chk_reg(4'h4, 32'h0000_E100 + k);
      wr(4'h0, 32'h0, 4'hF);
      issue(32'h0000_F100, 1'h0, 1'h0);
    end
    $display("test scalar bounce done");

    issue(32'h0000_0BAD, 1'h1, 1'h1);
    chk_reg(4'h0, 32'h0);
    $display("test illegal done");
    test_done();
  end
endmodule : tb_fp_coprocessor_bounce_unit
